// ===== core/pstcr_pkg.sv
package pstcr_pkg;

  // Device clock
  localparam int unsigned CLK_PERIOD_NS = 50;

  // Register addresses
  localparam logic [15:0] ADDR_OCP_SETTING = 16'hfe3e;
  localparam logic [15:0] ADDR_TEMP_HYST   = 16'hfe3f;
  localparam logic [15:0] ADDR_LINE_TRIM   = 16'hfe40;
  localparam logic [15:0] ADDR_FB_TRIM     = 16'hfe41;
  localparam logic [15:0] ADDR_CS_TRIM     = 16'hfe42;
  localparam logic [15:0] ADDR_BAL_GAIN    = 16'hfe43;
  localparam logic [15:0] ADDR_LP_THR      = 16'hfe44;

  // Field positions
  localparam int unsigned CURRENT_LIMIT_THRESHOLD_MSB       = 7;
  localparam int unsigned CURRENT_LIMIT_THRESHOLD_LSB       = 5;
  localparam int unsigned CURRENT_LIMIT_THRESHOLD_POL_BIT   = 7;
  localparam int unsigned CS_RANGE_BIT   = 1;
  localparam int unsigned LS_REF_BIT     = 0;
  localparam int unsigned TRIM_SIGN_BIT  = 7;
  localparam int unsigned BAL_EN_BIT     = 7;
  localparam int unsigned LP_THR_MSB     = 12;

  // Writable bits, reserved bits stay zero
  localparam logic [7:0]  OCP_WMASK = 8'he3;
  localparam logic [15:0] LP_WMASK  = 16'h1fff;
  localparam logic [2:0]  OCP_RSVD_ZERO = 3'h0;

  // Reset values
  localparam logic [7:0]  RST_BYTE = 8'h00;
  localparam logic [15:0] RST_WORD = 16'h0000;

  // Data widths
  localparam int unsigned TEMP_W  = 12;
  localparam int unsigned POWER_W = 13;
  localparam int unsigned VOUT_W  = 11;
  localparam int unsigned ERR_W   = 12;
  localparam int unsigned INTEG_W = 24;
  localparam int unsigned CORR_W  = 16;

  // Threshold current per limit code, microamps
  localparam logic [7:0] CURRENT_LIMIT_THRESHOLD_UA [8] = '{8'h14, 8'h28, 8'h3c, 8'h50, 8'h3c, 8'h50, 8'h64, 8'h78};
  localparam logic [7:0] CURRENT_LIMIT_THRESHOLD_POS_MAX_UA = 8'h50;
  localparam logic [7:0] CURRENT_LIMIT_THRESHOLD_NEG_MIN_UA = 8'h3c;

  // Overcurrent debounce times and cycle counts, rounded up
  localparam int unsigned DEB0_NS = 40;
  localparam int unsigned DEB1_NS = 80;
  localparam int unsigned DEB2_NS = 120;
  localparam int unsigned DEB3_NS = 240;
  localparam logic [2:0] DEB0_CYC = 3'((DEB0_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [2:0] DEB1_CYC = 3'((DEB1_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [2:0] DEB2_CYC = 3'((DEB2_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [2:0] DEB3_CYC = 3'((DEB3_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);

  // Register access request
  typedef struct packed {
    logic        wr;
    logic        rd;
    logic [15:0] addr;
    logic [15:0] wdata;
  } pstcr_req_t;

  // Sign-magnitude trim to two's complement
  function automatic logic signed [7:0] trim_gain(input logic [7:0] r);
    logic signed [7:0] m;
    m = $signed({1'b0, r[6:0]});
    return r[TRIM_SIGN_BIT] ? -m : m;
  endfunction : trim_gain

  function automatic logic [2:0] deb_cycles(input logic [1:0] sel);
    logic [2:0] c;
    unique case (sel)
      2'h0: c = DEB0_CYC;
      2'h1: c = DEB1_CYC;
      2'h2: c = DEB2_CYC;
      2'h3: c = DEB3_CYC;
    endcase
    return c;
  endfunction : deb_cycles

endpackage : pstcr_pkg

// ===== core/pstcr_hyst_flag.sv
`timescale 1ns/1ps
`default_nettype none
// Flag set below limit, cleared only above limit plus hysteresis or when enable is low
module pstcr_hyst_flag #(
  parameter int unsigned VW = 12,
  parameter int unsigned HW = 8
) (
  // Clock and reset
  input  wire logic          sysClk,
  input  wire logic          sysRst,
  input  wire logic          sysCe,
  // Comparison
  input  wire logic          enable,
  input  wire logic [VW-1:0] value,
  input  wire logic [VW-1:0] limit,
  input  wire logic [HW-1:0] hyst,
  // Result
  output logic               flag
);

  logic [VW:0] upper;
  logic        next_flag;

  always_comb begin
    upper     = {1'b0, limit} + {{(VW + 1 - HW){1'b0}}, hyst};
    next_flag = flag;
    if (!enable) begin
      next_flag = 1'b0;
    end else if (value < limit) begin
      next_flag = 1'b1;
    end else if ({1'b0, value} > upper) begin
      next_flag = 1'b0;
    end
  end

  always_ff @(posedge sysClk) begin
    if (sysRst) begin
      flag <= 1'b0;
    end else if (sysCe) begin
      flag <= next_flag;
    end
  end

  a_flag_hold: assert property (@(posedge sysClk) disable iff (sysRst)
    flag && enable && sysCe && ({1'b0, value} <= upper) |=> flag)
    else $error("flag cleared inside hysteresis band");

  a_flag_release: assert property (@(posedge sysClk) disable iff (sysRst)
    enable && sysCe && ({1'b0, value} > upper) |=> !flag)
    else $error("flag kept above limit plus hysteresis");

endmodule : pstcr_hyst_flag
`default_nettype wire

// ===== core/pstcr_ocp_debounce.sv
`timescale 1ns/1ps
`default_nettype none
// Fast overcurrent debounce and per-cycle PWM shutdown
module pstcr_ocp_debounce (
  // Clock and reset
  input  wire logic       sysClk,
  input  wire logic       sysRst,
  input  wire logic       sysCe,
  // Comparator and timing
  input  wire logic       aboveLimitPin,
  input  wire logic [1:0] debounceSel,
  input  wire logic       cycleStart,
  // Shutdown
  output logic            pwmOff
);

  logic       syncA;
  logic       syncB;
  logic [2:0] runCount;
  logic [2:0] next_runCount;
  logic       next_pwmOff;
  logic [2:0] need;

  always_comb begin
    need          = pstcr_pkg::deb_cycles(debounceSel);
    next_runCount = runCount;
    next_pwmOff   = pwmOff;
    if (cycleStart) begin
      next_runCount = 3'h0;
      next_pwmOff   = 1'b0;
    end else if (syncB) begin
      if (runCount < need) begin
        next_runCount = runCount + 3'h1;
      end
      if (runCount + 3'h1 >= need) begin
        next_pwmOff = 1'b1;
      end
    end else begin
      next_runCount = 3'h0;
    end
  end

  always_ff @(posedge sysClk) begin
    if (sysRst) begin
      syncA    <= 1'b0;
      syncB    <= 1'b0;
      runCount <= 3'h0;
      pwmOff   <= 1'b0;
    end else if (sysCe) begin
      syncA    <= aboveLimitPin;
      syncB    <= syncA;
      runCount <= next_runCount;
      pwmOff   <= next_pwmOff;
    end
  end

  a_trip_cause: assert property (@(posedge sysClk) disable iff (sysRst)
    $rose(pwmOff) |-> $past(syncB) && ($past(runCount) + 3'h1 >= $past(need)))
    else $error("shutdown without full debounce run");

  a_cycle_release: assert property (@(posedge sysClk) disable iff (sysRst)
    cycleStart && sysCe |=> !pwmOff)
    else $error("shutdown held into next switching cycle");

endmodule : pstcr_ocp_debounce
`default_nettype wire

// ===== core/pstcr_config_regs.sv
`timescale 1ns/1ps
`default_nettype none
// Function
// - Top limit bit picks sensing polarity: clear positive, set negative.
// - Limit codes map to 20,40,60,80 or 60,80,100,120 microamps.
// - Lowest setting bit picks level-shift reference: one resistor, zero bandgap.
// - Fault flag clears only when temperature exceeds fault limit plus hysteresis.
// - Warning flag clears only when temperature exceeds warning limit plus hysteresis.
// - Gain trim registers ignore writes unless the trim lock is released.
// - Trim top bit is sign: one negative, zero positive adjustment.
// - Line-voltage trim magnitude scales line-voltage sense gain with sign.
// - Feedback trim magnitude scales output-voltage sense gain with sign.
// - Current-sense trim applies to the 500 mV input range.
// - Balance enable runs balancing; disable stops it and resets integrator.
// - Balance gain is seven-bit unsigned, full range 0 to 127.
// - Low power below threshold selects low-line or high-line low-power target.
// - Low-power mode exits only above threshold plus power hysteresis, or when smart output voltage is disabled.
// - Overcurrent trips after debounce time above limit; PWM off rest of cycle.
module pstcr_config_regs (
  // Clock and reset
  input  wire logic                                 sysClk,
  input  wire logic                                 sysRst,
  input  wire logic                                 sysCe,
  // Register access
  input  wire pstcr_pkg::pstcr_req_t                req,
  input  wire logic                                 trimUnlock,
  output logic [15:0]                               rdData,
  output logic                                      rdValid,
  // Overcurrent and sense configuration
  output logic [2:0]                                currentLimitThreshold,
  output logic                                      ocpNegativeSense,
  output logic [7:0]                                ilimMicroamps,
  output logic                                      csRange500,
  output logic                                      levelShiftRefPick,
  input  wire logic                                 csAboveLimitPin,
  input  wire logic [1:0]                           ocpDebounceSel,
  input  wire logic                                 switchCycleStart,
  output logic                                      pwmShutdown,
  // Gain trims
  output logic signed [7:0]                         lineVoltageSenseGain,
  output logic signed [7:0]                         outputVoltageFeedbackGain,
  output logic signed [7:0]                         currentSenseGain,
  // Temperature
  input  wire logic [pstcr_pkg::TEMP_W-1:0]         temperatureSensor,
  input  wire logic [pstcr_pkg::TEMP_W-1:0]         faultLimit,
  input  wire logic [pstcr_pkg::TEMP_W-1:0]         warningLimit,
  output logic                                      overtempFaultFlag,
  output logic                                      overtempWarningFlag,
  // Phase current balance
  input  wire logic signed [pstcr_pkg::ERR_W-1:0]   phaseCurrentError,
  output logic                                      phaseCurrentBalanceOn,
  output logic signed [pstcr_pkg::CORR_W-1:0]       balanceCorrection,
  // Smart output voltage
  input  wire logic                                 smartVoutEnable,
  input  wire logic [pstcr_pkg::POWER_W-1:0]        inputPower,
  input  wire logic [7:0]                           powerHysteresis,
  input  wire logic                                 highLine,
  input  wire logic [pstcr_pkg::VOUT_W-1:0]         lowLineLowPowerVout,
  input  wire logic [pstcr_pkg::VOUT_W-1:0]         highLineLowPowerVout,
  input  wire logic [pstcr_pkg::VOUT_W-1:0]         nominalVout,
  output logic                                      lowPowerMode,
  output logic [pstcr_pkg::VOUT_W-1:0]              voutTarget
);

  // Register file
  logic [7:0]  ocpSetting;
  logic [7:0]  tempHyst;
  logic [7:0]  lineTrim;
  logic [7:0]  fbTrim;
  logic [7:0]  csTrim;
  logic [7:0]  balGain;
  logic [15:0] lowPowerThr;
  logic [7:0]  next_ocpSetting;
  logic [7:0]  next_tempHyst;
  logic [7:0]  next_lineTrim;
  logic [7:0]  next_fbTrim;
  logic [7:0]  next_csTrim;
  logic [7:0]  next_balGain;
  logic [15:0] next_lowPowerThr;
  logic [15:0] next_rdData;
  logic        next_rdValid;
  logic        trimWriteOk;

  always_comb begin
    next_ocpSetting  = ocpSetting;
    next_tempHyst    = tempHyst;
    next_lineTrim    = lineTrim;
    next_fbTrim      = fbTrim;
    next_csTrim      = csTrim;
    next_balGain     = balGain;
    next_lowPowerThr = lowPowerThr;
    trimWriteOk      = req.wr && trimUnlock;
    if (req.wr) begin
      unique case (req.addr)
        pstcr_pkg::ADDR_OCP_SETTING: next_ocpSetting = req.wdata[7:0] & pstcr_pkg::OCP_WMASK;
        pstcr_pkg::ADDR_TEMP_HYST:   next_tempHyst   = req.wdata[7:0];
        pstcr_pkg::ADDR_LINE_TRIM:   next_lineTrim   = trimWriteOk ? req.wdata[7:0] : lineTrim;
        pstcr_pkg::ADDR_FB_TRIM:     next_fbTrim     = trimWriteOk ? req.wdata[7:0] : fbTrim;
        pstcr_pkg::ADDR_CS_TRIM:     next_csTrim     = trimWriteOk ? req.wdata[7:0] : csTrim;
        pstcr_pkg::ADDR_BAL_GAIN:    next_balGain    = req.wdata[7:0];
        pstcr_pkg::ADDR_LP_THR:      next_lowPowerThr = req.wdata & pstcr_pkg::LP_WMASK;
        default: ;
      endcase
    end
  end

  // Read port, unmapped addresses read zero
  always_comb begin
    next_rdValid = req.rd;
    next_rdData  = pstcr_pkg::RST_WORD;
    if (req.rd) begin
      unique case (req.addr)
        pstcr_pkg::ADDR_OCP_SETTING: next_rdData = {8'h00, ocpSetting};
        pstcr_pkg::ADDR_TEMP_HYST:   next_rdData = {8'h00, tempHyst};
        pstcr_pkg::ADDR_LINE_TRIM:   next_rdData = {8'h00, lineTrim};
        pstcr_pkg::ADDR_FB_TRIM:     next_rdData = {8'h00, fbTrim};
        pstcr_pkg::ADDR_CS_TRIM:     next_rdData = {8'h00, csTrim};
        pstcr_pkg::ADDR_BAL_GAIN:    next_rdData = {8'h00, balGain};
        pstcr_pkg::ADDR_LP_THR:      next_rdData = lowPowerThr;
        default:                     next_rdData = pstcr_pkg::RST_WORD;
      endcase
    end
  end

  always_ff @(posedge sysClk) begin
    if (sysRst) begin
      ocpSetting  <= pstcr_pkg::RST_BYTE;
      tempHyst    <= pstcr_pkg::RST_BYTE;
      lineTrim    <= pstcr_pkg::RST_BYTE;
      fbTrim      <= pstcr_pkg::RST_BYTE;
      csTrim      <= pstcr_pkg::RST_BYTE;
      balGain     <= pstcr_pkg::RST_BYTE;
      lowPowerThr <= pstcr_pkg::RST_WORD;
      rdData      <= pstcr_pkg::RST_WORD;
      rdValid     <= 1'b0;
    end else if (sysCe) begin
      ocpSetting  <= next_ocpSetting;
      tempHyst    <= next_tempHyst;
      lineTrim    <= next_lineTrim;
      fbTrim      <= next_fbTrim;
      csTrim      <= next_csTrim;
      balGain     <= next_balGain;
      lowPowerThr <= next_lowPowerThr;
      rdData      <= next_rdData;
      rdValid     <= next_rdValid;
    end
  end

  // Decoded configuration outputs
  logic [2:0]        next_currentLimitThreshold;
  logic              next_ocpNegativeSense;
  logic [7:0]        next_ilimMicroamps;
  logic              next_csRange500;
  logic              next_levelShiftRefPick;
  logic signed [7:0] next_lineGain;
  logic signed [7:0] next_fbGain;
  logic signed [7:0] next_csGain;

  always_comb begin
    next_currentLimitThreshold = ocpSetting[pstcr_pkg::CURRENT_LIMIT_THRESHOLD_MSB:pstcr_pkg::CURRENT_LIMIT_THRESHOLD_LSB];
    next_ocpNegativeSense      = ocpSetting[pstcr_pkg::CURRENT_LIMIT_THRESHOLD_POL_BIT];
    next_ilimMicroamps         = pstcr_pkg::CURRENT_LIMIT_THRESHOLD_UA[next_currentLimitThreshold];
    next_csRange500            = ocpSetting[pstcr_pkg::CS_RANGE_BIT];
    next_levelShiftRefPick     = ocpSetting[pstcr_pkg::LS_REF_BIT];
    next_lineGain              = pstcr_pkg::trim_gain(lineTrim);
    next_fbGain                = pstcr_pkg::trim_gain(fbTrim);
    // Trim only corrects the 500 mV range
    next_csGain                = next_csRange500 ? pstcr_pkg::trim_gain(csTrim) : 8'sh00;
  end

  always_ff @(posedge sysClk) begin
    if (sysRst) begin
      currentLimitThreshold     <= 3'h0;
      ocpNegativeSense          <= 1'b0;
      ilimMicroamps             <= pstcr_pkg::CURRENT_LIMIT_THRESHOLD_UA[0];
      csRange500                <= 1'b0;
      levelShiftRefPick         <= 1'b0;
      lineVoltageSenseGain      <= 8'sh00;
      outputVoltageFeedbackGain <= 8'sh00;
      currentSenseGain          <= 8'sh00;
    end else if (sysCe) begin
      currentLimitThreshold     <= next_currentLimitThreshold;
      ocpNegativeSense          <= next_ocpNegativeSense;
      ilimMicroamps             <= next_ilimMicroamps;
      csRange500                <= next_csRange500;
      levelShiftRefPick         <= next_levelShiftRefPick;
      lineVoltageSenseGain      <= next_lineGain;
      outputVoltageFeedbackGain <= next_fbGain;
      currentSenseGain          <= next_csGain;
    end
  end

  // Overtemperature flags with shared hysteresis
  pstcr_hyst_flag #(.VW(pstcr_pkg::TEMP_W), .HW(8)) u_fault_flag (
    .sysClk (sysClk),
    .sysRst (sysRst),
    .sysCe  (sysCe),
    .enable (1'b1),
    .value  (temperatureSensor),
    .limit  (faultLimit),
    .hyst   (tempHyst),
    .flag   (overtempFaultFlag)
  );

  pstcr_hyst_flag #(.VW(pstcr_pkg::TEMP_W), .HW(8)) u_warn_flag (
    .sysClk (sysClk),
    .sysRst (sysRst),
    .sysCe  (sysCe),
    .enable (1'b1),
    .value  (temperatureSensor),
    .limit  (warningLimit),
    .hyst   (tempHyst),
    .flag   (overtempWarningFlag)
  );

  // Low-power mode of smart output voltage
  pstcr_hyst_flag #(.VW(pstcr_pkg::POWER_W), .HW(8)) u_low_power (
    .sysClk (sysClk),
    .sysRst (sysRst),
    .sysCe  (sysCe),
    .enable (smartVoutEnable),
    .value  (inputPower),
    .limit  (lowPowerThr[pstcr_pkg::LP_THR_MSB:0]),
    .hyst   (powerHysteresis),
    .flag   (lowPowerMode)
  );

  logic [pstcr_pkg::VOUT_W-1:0] next_voutTarget;

  always_comb begin
    next_voutTarget = nominalVout;
    if (lowPowerMode) begin
      next_voutTarget = highLine ? highLineLowPowerVout : lowLineLowPowerVout;
    end
  end

  always_ff @(posedge sysClk) begin
    if (sysRst) begin
      voutTarget <= '0;
    end else if (sysCe) begin
      voutTarget <= next_voutTarget;
    end
  end

  // Phase current balance integrator
  logic                                 balEnable;
  logic signed [pstcr_pkg::ERR_W+7:0]   balProduct;
  logic signed [pstcr_pkg::INTEG_W-1:0] balInteg;
  logic signed [pstcr_pkg::INTEG_W-1:0] next_balInteg;

  always_comb begin
    balEnable     = balGain[pstcr_pkg::BAL_EN_BIT];
    balProduct    = phaseCurrentError * $signed({1'b0, balGain[6:0]});
    next_balInteg = '0;
    if (balEnable) begin
      next_balInteg = balInteg + pstcr_pkg::INTEG_W'(balProduct);
    end
  end

  always_ff @(posedge sysClk) begin
    if (sysRst) begin
      balInteg              <= '0;
      phaseCurrentBalanceOn <= 1'b0;
      balanceCorrection     <= '0;
    end else if (sysCe) begin
      balInteg              <= next_balInteg;
      phaseCurrentBalanceOn <= balEnable;
      balanceCorrection     <= next_balInteg[pstcr_pkg::INTEG_W-1 -: pstcr_pkg::CORR_W];
    end
  end

  // Fast overcurrent shutdown
  pstcr_ocp_debounce u_ocp (
    .sysClk        (sysClk),
    .sysRst        (sysRst),
    .sysCe         (sysCe),
    .aboveLimitPin (csAboveLimitPin),
    .debounceSel   (ocpDebounceSel),
    .cycleStart    (switchCycleStart),
    .pwmOff        (pwmShutdown)
  );

  a_trim_locked: assert property (@(posedge sysClk) disable iff (sysRst)
    sysCe && req.wr && !trimUnlock && (req.addr == pstcr_pkg::ADDR_LINE_TRIM) |=> $stable(lineTrim))
    else $error("locked trim register accepted a write");

  a_trim_unlocked: assert property (@(posedge sysClk) disable iff (sysRst)
    sysCe && req.wr && trimUnlock && (req.addr == pstcr_pkg::ADDR_FB_TRIM) |=> fbTrim == $past(req.wdata[7:0]))
    else $error("unlocked trim register missed a write");

  a_current_limit_threshold_polarity: assert property (@(posedge sysClk) disable iff (sysRst)
    ocpNegativeSense == currentLimitThreshold[2])
    else $error("sense polarity not taken from top limit bit");

  a_current_limit_threshold_range: assert property (@(posedge sysClk) disable iff (sysRst)
    ocpNegativeSense ? (ilimMicroamps >= pstcr_pkg::CURRENT_LIMIT_THRESHOLD_NEG_MIN_UA) : (ilimMicroamps <= pstcr_pkg::CURRENT_LIMIT_THRESHOLD_POS_MAX_UA))
    else $error("threshold current out of range for polarity");

  a_trim_sign: assert property (@(posedge sysClk) disable iff (sysRst)
    sysCe && lineTrim[pstcr_pkg::TRIM_SIGN_BIT] && (lineTrim[6:0] != 7'h00) |=> lineVoltageSenseGain < 0)
    else $error("negative trim sign gave non-negative gain");

  a_cs_range: assert property (@(posedge sysClk) disable iff (sysRst)
    !csRange500 |-> currentSenseGain == 8'sh00)
    else $error("current trim applied outside 500 mV range");

  a_bal_reset: assert property (@(posedge sysClk) disable iff (sysRst)
    sysCe && !balGain[pstcr_pkg::BAL_EN_BIT] |=> balInteg == '0 && balanceCorrection == '0)
    else $error("balance integrator not reset while disabled");

  a_lp_target: assert property (@(posedge sysClk) disable iff (sysRst)
    sysCe && lowPowerMode && highLine |=> voutTarget == $past(highLineLowPowerVout))
    else $error("high line low-power target not selected");

  a_reserved_zero: assert property (@(posedge sysClk) disable iff (sysRst)
    ocpSetting[4:2] == pstcr_pkg::OCP_RSVD_ZERO && lowPowerThr[15:13] == 3'h0)
    else $error("reserved bits hold a written value");

endmodule : pstcr_config_regs
`default_nettype wire

// ===== verif/pstcr_host_model.sv
`timescale 1ns/1ps
`default_nettype none
module pstcr_host_model (
  // Clock
  input  wire logic                  sysClk,
  // Register access
  output var pstcr_pkg::pstcr_req_t  req,
  output logic                       trimUnlock,
  input  wire logic [15:0]           rdData,
  input  wire logic                  rdValid
);
  initial begin
    req = '0;
    trimUnlock = 1'b0;
  end
  task automatic unlock(input logic on);
    @(negedge sysClk);
    trimUnlock = on;
  endtask : unlock
  // Released bus shows inverted address and data
  task automatic wr(input logic [15:0] a, input logic [15:0] d);
    @(negedge sysClk);
    req = {1'b1, 1'b0, a, d};
    @(negedge sysClk);
    req = {1'b0, 1'b0, ~a, ~d};
  endtask : wr
  task automatic rd(input logic [15:0] a, output logic [16:0] r);
    @(negedge sysClk);
    req = {1'b0, 1'b1, a, 16'h0000};
    @(negedge sysClk);
    req = {1'b0, 1'b0, ~a, 16'hffff};
    r = {rdValid, rdData};
  endtask : rd
endmodule : pstcr_host_model
`default_nettype wire

// ===== verif/testbench.sv
`timescale 1ns/1ps
`default_nettype none
module testbench;
  logic sysClk = 1'b0, sysRst = 1'b1, sysCe = 1'b1;
  pstcr_pkg::pstcr_req_t req;
  logic trimUnlock, rdValid, ocpNegativeSense, csRange500, levelShiftRefPick, pwmShutdown;
  logic overtempFaultFlag, overtempWarningFlag, phaseCurrentBalanceOn, lowPowerMode;
  logic smartVoutEnable = 1'b0, highLine = 1'b0, csAboveLimitPin = 1'b0, switchCycleStart = 1'b0;
  logic [1:0] ocpDebounceSel = 2'h3;
  logic [2:0] currentLimitThreshold;
  logic [7:0] ilimMicroamps, powerHysteresis = 8'h20;
  logic [15:0] rdData;
  logic signed [7:0] lineVoltageSenseGain, outputVoltageFeedbackGain, currentSenseGain;
  logic [11:0] temperatureSensor = 12'h000, faultLimit = 12'h064, warningLimit = 12'h050;
  logic signed [11:0] phaseCurrentError = 12'h100;
  logic signed [15:0] balanceCorrection;
  logic [12:0] inputPower = 13'h1fff;
  logic [10:0] lowLineLowPowerVout = 11'h123, highLineLowPowerVout = 11'h456, nominalVout = 11'h700, voutTarget;
  int mismatches = 0, totalChecks = 0, cycles = 0;

  pstcr_config_regs DUT (.sysClk, .sysRst, .sysCe, .req, .trimUnlock, .rdData, .rdValid,
    .currentLimitThreshold, .ocpNegativeSense, .ilimMicroamps, .csRange500, .levelShiftRefPick,
    .csAboveLimitPin, .ocpDebounceSel, .switchCycleStart, .pwmShutdown, .lineVoltageSenseGain,
    .outputVoltageFeedbackGain, .currentSenseGain, .temperatureSensor, .faultLimit, .warningLimit,
    .overtempFaultFlag, .overtempWarningFlag, .phaseCurrentError, .phaseCurrentBalanceOn,
    .balanceCorrection, .smartVoutEnable, .inputPower, .powerHysteresis, .highLine,
    .lowLineLowPowerVout, .highLineLowPowerVout, .nominalVout, .lowPowerMode, .voutTarget);
  pstcr_host_model host (.sysClk, .req, .trimUnlock, .rdData, .rdValid);

  always #25 sysClk = ~sysClk;
  always @(posedge sysClk) begin
    cycles++;
    if (cycles == 5000) begin
      mismatches++;
      give_verdict();
    end
  end

  task automatic give_verdict;
    $display("checks %0d mismatches %0d", totalChecks, mismatches);
    if (mismatches == 0 && totalChecks > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask : give_verdict
  task automatic chk(input logic [16:0] got, input logic [16:0] exp);
    totalChecks++;
    if (got !== exp) begin
      mismatches++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task automatic cyc(input int n);
    repeat (n) @(negedge sysClk);
  endtask : cyc
  task automatic rdchk(input logic [15:0] a, input logic [15:0] e);
    logic [16:0] r;
    host.rd(a, r);
    chk(r, {1'b1, e});
  endtask : rdchk

  task automatic t_reset;
    for (int i = 0; i < 8; i++) rdchk(16'hfe3e + 16'(i), 16'h0000);
    chk(17'(ilimMicroamps), 17'h00014);
    $display("reset test done");
  endtask : t_reset
  task automatic t_ocp;
    logic [7:0] ua [8] = '{8'h14, 8'h28, 8'h3c, 8'h50, 8'h3c, 8'h50, 8'h64, 8'h78};
    for (int c = 0; c < 8; c++) begin
      host.wr(16'hfe3e, {8'hff, 3'(c), 4'hf, 1'(c)});
      rdchk(16'hfe3e, {8'h00, 3'(c), 4'h1, 1'(c)});
      chk(17'(currentLimitThreshold), 17'(c));
      chk(17'(ilimMicroamps), 17'(ua[c]));
      chk(17'(ocpNegativeSense), 17'(c >> 2));
      chk(17'(levelShiftRefPick), 17'(c & 1));
      chk(17'(csRange500), 17'h1);
    end
    $display("ocp setting test done");
  endtask : t_ocp
  task automatic t_trim;
    host.wr(16'hfe40, 16'h0085);
    rdchk(16'hfe40, 16'h0000);
    host.unlock(1'b1);
    host.wr(16'hfe40, 16'h0085);
    host.wr(16'hfe41, 16'h0005);
    host.wr(16'hfe42, 16'h00ff);
    cyc(1);
    chk(17'($unsigned(lineVoltageSenseGain)), 17'h000fb);
    chk(17'($unsigned(outputVoltageFeedbackGain)), 17'h00005);
    chk(17'($unsigned(currentSenseGain)), 17'h00081);
    host.wr(16'hfe3e, 16'h0000);
    cyc(1);
    chk(17'(csRange500), 17'h0);
    chk(17'($unsigned(currentSenseGain)), 17'h00000);
    $display("trim test done");
  endtask : t_trim
  task automatic t_temp;
    host.wr(16'hfe3f, 16'h0010);
    temperatureSensor = 12'h040;
    cyc(2);
    chk({15'h0, overtempFaultFlag, overtempWarningFlag}, 17'h3);
    temperatureSensor = 12'h074;
    cyc(2);
    chk({15'h0, overtempFaultFlag, overtempWarningFlag}, 17'h2);
    temperatureSensor = 12'h075;
    cyc(2);
    chk(17'(overtempFaultFlag), 17'h0);
    // Clock enable low freezes the flags
    sysCe = 1'b0;
    temperatureSensor = 12'h040;
    cyc(2);
    chk({15'h0, overtempFaultFlag, overtempWarningFlag}, 17'h0);
    sysCe = 1'b1;
    cyc(2);
    chk({15'h0, overtempFaultFlag, overtempWarningFlag}, 17'h3);
    $display("temperature test done");
  endtask : t_temp
  task automatic t_bal;
    logic [15:0] c0, d;
    for (int g = 0; g < 2; g++) begin
      host.wr(16'hfe43, g ? 16'h00ff : 16'h0081);
      cyc(2);
      chk(17'(phaseCurrentBalanceOn), 17'h1);
      c0 = balanceCorrection;
      cyc(1);
      d = balanceCorrection - c0;
      chk(17'(d), g ? 17'h0007f : 17'h00001);
    end
    host.wr(16'hfe43, 16'h007f);
    cyc(2);
    chk({phaseCurrentBalanceOn, balanceCorrection}, 17'h0);
    $display("balance test done");
  endtask : t_bal
  task automatic t_lp;
    host.wr(16'hfe44, 16'he100);
    rdchk(16'hfe44, 16'h0100);
    smartVoutEnable = 1'b1;
    inputPower = 13'h00ff;
    cyc(3);
    chk({5'h0, lowPowerMode, voutTarget}, 17'h00923);
    highLine = 1'b1;
    inputPower = 13'h0120;
    cyc(2);
    chk({5'h0, lowPowerMode, voutTarget}, 17'h00c56);
    inputPower = 13'h0121;
    cyc(3);
    chk({5'h0, lowPowerMode, voutTarget}, 17'h00700);
    $display("low power test done");
  endtask : t_lp
  task automatic t_trip;
    // One low cycle restarts the 240 ns run
    csAboveLimitPin = 1'b1;
    cyc(4);
    csAboveLimitPin = 1'b0;
    cyc(1);
    csAboveLimitPin = 1'b1;
    cyc(6);
    chk(17'(pwmShutdown), 17'h0);
    cyc(1);
    chk(17'(pwmShutdown), 17'h1);
    csAboveLimitPin = 1'b0;
    cyc(2);
    chk(17'(pwmShutdown), 17'h1);
    switchCycleStart = 1'b1;
    ocpDebounceSel = 2'h0;
    cyc(1);
    switchCycleStart = 1'b0;
    chk(17'(pwmShutdown), 17'h0);
    // Shortest debounce trips on the first synced high
    csAboveLimitPin = 1'b1;
    cyc(2);
    chk(17'(pwmShutdown), 17'h0);
    cyc(1);
    chk(17'(pwmShutdown), 17'h1);
    $display("overcurrent test done");
  endtask : t_trip

  initial begin
    cyc(12);
    sysRst = 1'b0;
    t_reset();
    t_ocp();
    t_trim();
    t_temp();
    t_bal();
    t_lp();
    t_trip();
    give_verdict();
  end
endmodule : testbench
`default_nettype wire
